// ==== tbam_consts.svh ====
// Purpose : Offsets, field positions, reset values and timing counts of the two-wire byte access master
// Assumes : Included by bare name from every design file that needs it
// Notes   : Definitions only
`ifndef TBAM_CONSTS_SVH
`define TBAM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets on the configuration port
// ----------------------------------------------------------------
`define TBAM_OFF_XFER_BYTE   8'hb0
`define TBAM_OFF_BYTE_PTR    8'hb1
`define TBAM_OFF_TARGET      8'hb2
`define TBAM_OFF_CTRL_STAT   8'hb3

// ----------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------
`define TBAM_BIT_SHORT_SEL   7
`define TBAM_BIT_RSVD        6
`define TBAM_BIT_IN_FLIGHT   5
`define TBAM_BIT_AUTOLOAD    4
`define TBAM_BIT_LINK        3
`define TBAM_BIT_FAST_TEST   2
`define TBAM_BIT_REQ_FAULT   1
`define TBAM_BIT_ROM_FAULT   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TBAM_RST_BYTE        8'h00
`define TBAM_RST_BIT         1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TBAM_CLK_PERIOD_NS   10
`define TBAM_SCL_NORM_NS     10000
`define TBAM_SCL_TEST_NS     2500
`define TBAM_QTR_NORM_CYC    (`TBAM_SCL_NORM_NS / (4 * `TBAM_CLK_PERIOD_NS))
`define TBAM_QTR_TEST_CYC    (`TBAM_SCL_TEST_NS / (4 * `TBAM_CLK_PERIOD_NS))
`define TBAM_DETECT_WAIT     4'h4

`endif

// ==== tbam_pkg.sv ====
// Purpose : Types shared by the two-wire byte access master
// Assumes : Nothing
// Notes   : Constants live in tbam_consts.svh
package tbam_pkg;

    typedef logic [7:0] tbam_byte_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_XFER,
        ST_STOP
    } tbam_state_e;

    typedef enum logic [2:0] {
        SQ_ADDR1,
        SQ_PTR,
        SQ_DATA,
        SQ_ADDR2,
        SQ_RDATA,
        SQ_DONE
    } tbam_seq_e;

endpackage : tbam_pkg

// ==== tbam_sync.sv ====
// Purpose : Two-flop synchroniser for pin levels
// Assumes : Inputs are asynchronous levels
// Notes   : First stage feeds only the second
`timescale 1ns/1ps
module tbam_sync #(
    parameter int W = 2
) (
    input  wire logic         i_mclk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_reg <= '1;
            o_sync   <= '1;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : tbam_sync

// ==== tbam_qtick.sv ====
// Purpose : Quarter-period tick for the serial-bus clock
// Assumes : Counts are at least 1
// Notes   : Rate change takes effect at the next reload
`timescale 1ns/1ps
`include "tbam_consts.svh"
module tbam_qtick #(
    parameter logic [15:0] NORM_Q = 16'(`TBAM_QTR_NORM_CYC),
    parameter logic [15:0] TEST_Q = 16'(`TBAM_QTR_TEST_CYC)
) (
    input  wire logic i_mclk,
    input  wire logic i_arst_n,
    input  wire logic i_fast,
    output logic      o_tick
);
    logic [15:0] cnt_reg;

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_reg <= 16'h0000;
            o_tick  <= 1'b0;
        end
        else if (cnt_reg == 16'h0000)
        begin
            cnt_reg <= (i_fast ? TEST_Q : NORM_Q) - 16'h0001;
            o_tick  <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg - 16'h0001;
            o_tick  <= 1'b0;
        end
    end
endmodule : tbam_qtick

// ==== tbam_top.sv ====
// Purpose : Host-programmed two-wire bus master doing single byte reads and writes
// Assumes : Config port is synchronous to i_mclk; serial pins are open drain and asynchronous
// Notes   : Auto-load engine is outside; its busy level and fault pulse enter here
`timescale 1ns/1ps
`include "tbam_consts.svh"

module tbam_top #(
    parameter logic [15:0] NORM_Q = 16'(`TBAM_QTR_NORM_CYC),
    parameter logic [15:0] TEST_Q = 16'(`TBAM_QTR_TEST_CYC)
) (
    // Clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_arst_n,
    // Configuration port
    input  wire logic [7:0]           i_cfg_addr,
    input  wire logic                 i_cfg_wr,
    input  wire logic                 i_cfg_rd,
    input  wire tbam_pkg::tbam_byte_t i_cfg_wdata,
    output tbam_pkg::tbam_byte_t      o_cfg_rdata,
    // Auto-load status
    input  wire logic                 i_autoload_active,
    input  wire logic                 i_autoload_fault,
    // Serial bus pins
    input  wire logic                 i_scl,
    output logic                      o_scl_o,
    output logic                      o_scl_oe,
    input  wire logic                 i_sda,
    output logic                      o_sda_o,
    output logic                      o_sda_oe,
    // Status
    output logic                      o_request_in_flight,
    output logic                      o_link_present
);
    import tbam_pkg::*;

    tbam_byte_t  xfer_byte_reg, byte_ptr_reg, target_reg, sh_reg;
    logic        short_sel_reg, fast_test_reg, req_fault_reg, rom_fault_reg, autoload_reg;
    tbam_state_e state_reg;
    tbam_seq_e   seq_reg;
    logic [1:0]  q_reg;
    logic [3:0]  bit_reg, det_reg;
    logic        short_lat_reg, rd_lat_reg, ack_bad_reg, done_reg, nack_reg, rx_done_reg;
    logic        tick, scl_s, sda_s, is_rx, start_req;
    logic [1:0]  pins_s;
    tbam_seq_e   nxt_seq;

    assign scl_s     = pins_s[1];
    assign sda_s     = pins_s[0];
    assign is_rx     = (seq_reg == SQ_RDATA);
    assign start_req = i_cfg_wr && (i_cfg_addr == `TBAM_OFF_TARGET) && !o_request_in_flight;
    assign nxt_seq   = next_seq(seq_reg, short_lat_reg, rd_lat_reg);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic tbam_seq_e next_seq(input tbam_seq_e s, input logic sh, input logic rd);
        case (s)
            SQ_ADDR1: next_seq = sh ? (rd ? SQ_RDATA : SQ_DATA) : SQ_PTR;
            SQ_PTR:   next_seq = rd ? SQ_ADDR2 : SQ_DATA;
            SQ_ADDR2: next_seq = SQ_RDATA;
            default:  next_seq = SQ_DONE;
        endcase
    endfunction : next_seq

    // Outgoing byte for each step of the frame
    function automatic tbam_byte_t tx_byte(input tbam_seq_e s);
        case (s)
            SQ_ADDR1: tx_byte = {target_reg[7:1], short_lat_reg & rd_lat_reg};
            SQ_PTR:   tx_byte = byte_ptr_reg;
            SQ_DATA:  tx_byte = xfer_byte_reg;
            SQ_ADDR2: tx_byte = {target_reg[7:1], 1'b1};
            default:  tx_byte = 8'hff;
        endcase
    endfunction : tx_byte

    tbam_sync #(.W(2)) u_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_async  ({i_scl, i_sda}),
        .o_sync   (pins_s)
    );

    tbam_qtick #(.NORM_Q(NORM_Q), .TEST_Q(TEST_Q)) u_qtick (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_fast   (fast_test_reg),
        .o_tick   (tick)
    );

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            xfer_byte_reg <= `TBAM_RST_BYTE;
            byte_ptr_reg  <= `TBAM_RST_BYTE;
            target_reg    <= `TBAM_RST_BYTE;
            short_sel_reg <= `TBAM_RST_BIT;
            fast_test_reg <= `TBAM_RST_BIT;
        end
        else
        begin
            if (rx_done_reg)
                xfer_byte_reg <= sh_reg;
            else if (i_cfg_wr && i_cfg_addr == `TBAM_OFF_XFER_BYTE)
                xfer_byte_reg <= i_cfg_wdata;
            if (i_cfg_wr && i_cfg_addr == `TBAM_OFF_BYTE_PTR)
                byte_ptr_reg <= i_cfg_wdata;
            if (start_req)
                target_reg <= i_cfg_wdata;
            if (i_cfg_wr && i_cfg_addr == `TBAM_OFF_CTRL_STAT)
            begin
                short_sel_reg <= i_cfg_wdata[`TBAM_BIT_SHORT_SEL];
                fast_test_reg <= i_cfg_wdata[`TBAM_BIT_FAST_TEST];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sticky faults, set wins over write-one-to-clear
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            req_fault_reg <= `TBAM_RST_BIT;
            rom_fault_reg <= `TBAM_RST_BIT;
            autoload_reg  <= `TBAM_RST_BIT;
        end
        else
        begin
            autoload_reg <= i_autoload_active;
            if (nack_reg)
                req_fault_reg <= 1'b1;
            else if (i_cfg_wr && i_cfg_addr == `TBAM_OFF_CTRL_STAT && i_cfg_wdata[`TBAM_BIT_REQ_FAULT])
                req_fault_reg <= 1'b0;
            if (i_autoload_fault)
                rom_fault_reg <= 1'b1;
            else if (i_cfg_wr && i_cfg_addr == `TBAM_OFF_CTRL_STAT && i_cfg_wdata[`TBAM_BIT_ROM_FAULT])
                rom_fault_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Link detection after reset release
    // ----------------------------------------------------------------
    // Waits until the synchroniser holds real pin levels, then samples once
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            det_reg        <= 4'h0;
            o_link_present <= 1'b0;
        end
        else if (det_reg != `TBAM_DETECT_WAIT)
        begin
            det_reg <= det_reg + 4'h1;
            if (det_reg == `TBAM_DETECT_WAIT - 4'h1)
                o_link_present <= scl_s & sda_s;
        end
    end

    // ----------------------------------------------------------------
    // Read data and in-flight flag
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_cfg_rdata         <= `TBAM_RST_BYTE;
            o_request_in_flight <= `TBAM_RST_BIT;
        end
        else
        begin
            if (start_req)
                o_request_in_flight <= 1'b1;
            else if (done_reg)
                o_request_in_flight <= 1'b0;
            if (i_cfg_rd)
            begin
                case (i_cfg_addr)
                    `TBAM_OFF_XFER_BYTE: o_cfg_rdata <= xfer_byte_reg;
                    `TBAM_OFF_BYTE_PTR:  o_cfg_rdata <= byte_ptr_reg;
                    `TBAM_OFF_TARGET:    o_cfg_rdata <= target_reg;
                    `TBAM_OFF_CTRL_STAT: o_cfg_rdata <= {short_sel_reg, 1'b0, o_request_in_flight,
                                                         autoload_reg, o_link_present, fast_test_reg,
                                                         req_fault_reg, rom_fault_reg};
                    default:             o_cfg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus engine, four quarters per bus clock
    // ----------------------------------------------------------------
    // Quarter 2 waits for the pin to read high, so a target may stretch the clock
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg     <= ST_IDLE;
            seq_reg       <= SQ_ADDR1;
            q_reg         <= 2'd0;
            bit_reg       <= 4'h0;
            sh_reg        <= 8'h00;
            short_lat_reg <= 1'b0;
            rd_lat_reg    <= 1'b0;
            ack_bad_reg   <= 1'b0;
            done_reg      <= 1'b0;
            nack_reg      <= 1'b0;
            rx_done_reg   <= 1'b0;
            o_scl_oe      <= 1'b0;
            o_sda_oe      <= 1'b0;
            o_scl_o       <= 1'b0;
            o_sda_o       <= 1'b0;
        end
        else
        begin
            done_reg    <= 1'b0;
            nack_reg    <= 1'b0;
            rx_done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (start_req)
                    begin
                        state_reg     <= ST_START;
                        seq_reg       <= SQ_ADDR1;
                        q_reg         <= 2'd0;
                        short_lat_reg <= short_sel_reg;
                        rd_lat_reg    <= i_cfg_wdata[0];
                    end
                end
                ST_START:
                begin
                    if (tick && (q_reg != 2'd2 || scl_s))
                    begin
                        q_reg <= q_reg + 2'd1;
                        case (q_reg)
                            2'd0:    o_sda_oe <= 1'b0;
                            2'd1:    o_scl_oe <= 1'b0;
                            2'd2:    o_sda_oe <= 1'b1;
                            default:
                            begin
                                o_scl_oe  <= 1'b1;
                                state_reg <= ST_XFER;
                                bit_reg   <= 4'h0;
                                sh_reg    <= tx_byte(seq_reg);
                            end
                        endcase
                    end
                end
                ST_XFER:
                begin
                    if (tick && (q_reg != 2'd2 || scl_s))
                    begin
                        q_reg <= q_reg + 2'd1;
                        case (q_reg)
                            2'd0:    o_sda_oe <= (bit_reg < 4'h8) && !is_rx && !sh_reg[7];
                            2'd1:    o_scl_oe <= 1'b0;
                            2'd2:
                            begin
                                if (bit_reg < 4'h8 && is_rx)
                                    sh_reg <= {sh_reg[6:0], sda_s};
                                ack_bad_reg <= sda_s;
                            end
                            default:
                            begin
                                o_scl_oe <= 1'b1;
                                if (bit_reg != 4'h8)
                                begin
                                    bit_reg <= bit_reg + 4'h1;
                                    if (!is_rx)
                                        sh_reg <= {sh_reg[6:0], 1'b0};
                                end
                                else if (!is_rx && ack_bad_reg)
                                begin
                                    nack_reg  <= 1'b1;
                                    state_reg <= ST_STOP;
                                end
                                else
                                begin
                                    rx_done_reg <= is_rx;
                                    seq_reg     <= nxt_seq;
                                    bit_reg     <= 4'h0;
                                    // A received byte must survive until the store one edge later
                                    if (!is_rx)
                                        sh_reg <= tx_byte(nxt_seq);
                                    if (nxt_seq == SQ_DONE)
                                        state_reg <= ST_STOP;
                                    else if (nxt_seq == SQ_ADDR2)
                                        state_reg <= ST_START;
                                end
                            end
                        endcase
                    end
                end
                ST_STOP:
                begin
                    if (tick && (q_reg != 2'd2 || scl_s))
                    begin
                        q_reg <= q_reg + 2'd1;
                        case (q_reg)
                            2'd0:    o_sda_oe <= 1'b1;
                            2'd1:    o_scl_oe <= 1'b0;
                            2'd2:    o_scl_oe <= 1'b0;
                            default:
                            begin
                                o_sda_oe  <= 1'b0;
                                state_reg <= ST_IDLE;
                                done_reg  <= 1'b1;
                            end
                        endcase
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    sequence s_target_write;
        start_req;
    endsequence

    sequence s_status_read;
        i_cfg_rd && i_cfg_addr == `TBAM_OFF_CTRL_STAT;
    endsequence

    busy_set_a: assert property (s_target_write |=> o_request_in_flight && state_reg == ST_START)
        else $error("request not started after target write");
    busy_clear_a: assert property (done_reg |=> !o_request_in_flight && state_reg == ST_IDLE)
        else $error("in-flight flag not cleared at end");
    reserved_zero_a: assert property (s_status_read |=> o_cfg_rdata[`TBAM_BIT_RSVD] == 1'b0)
        else $error("reserved bit reads nonzero");
    target_hold_a: assert property (s_target_write |=> target_reg == $past(i_cfg_wdata))
        else $error("target register lost written value");
    read_dir_a: assert property (state_reg == ST_XFER && seq_reg == SQ_ADDR2 && bit_reg == 4'h7
                                 && q_reg == 2'd2 |-> !o_sda_oe)
        else $error("read direction bit driven low");
    short_skip_a: assert property (short_lat_reg && state_reg != ST_IDLE
                                   |-> seq_reg != SQ_PTR && seq_reg != SQ_ADDR2)
        else $error("pointer sent in short framing");
    autoload_mirror_a: assert property (i_autoload_active |=> autoload_reg)
        else $error("auto-load busy not shown");
    req_fault_a: assert property (nack_reg |=> req_fault_reg [*2])
        else $error("request fault not held");
    rom_fault_a: assert property (i_autoload_fault |=> rom_fault_reg)
        else $error("auto-load fault not set");
    // Cycles since the last quarter tick, so the rate check follows the parameters
    logic [15:0] gap_reg;
    logic        gap_seen_reg;

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            gap_reg      <= 16'h0000;
            gap_seen_reg <= 1'b0;
        end
        else if (tick)
        begin
            gap_reg      <= 16'h0000;
            gap_seen_reg <= 1'b1;
        end
        else
            gap_reg <= gap_reg + 16'h0001;
    end

    tick_rate_a: assert property (tick && gap_seen_reg
                                  |-> gap_reg == NORM_Q - 16'h0001 || gap_reg == TEST_Q - 16'h0001)
        else $error("bus clock quarter length wrong");
    rx_store_a: assert property (rx_done_reg |=> xfer_byte_reg == $past(sh_reg))
        else $error("received byte not stored");

endmodule : tbam_top

// ==== tbam_target_model.sv ====
// Purpose : Behavioural two-wire target with byte memory and pointer
// Assumes : Lines are open drain with pull-ups; levels are resolved in the bench
// Notes   : Acks only its own address; i_nack forces a missing acknowledge
`timescale 1ns/1ps
module tbam_target_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic i_short,
    input  wire logic i_nack,
    output logic      o_sda_oe
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    int         bitc;
    int         ph = 3;
    logic       rd;
    initial o_sda_oe = 1'b0;
    always @(negedge i_sda) if (i_scl) begin bitc = 0; ph = 0; rd = 0; o_sda_oe = 0; end
    always @(posedge i_sda) if (i_scl) begin ph = 3; o_sda_oe = 0; end
    always @(posedge i_scl) if (ph != 3)
    begin
        if (bitc < 8) begin sh = {sh[6:0], i_sda}; bitc++; end
        else begin bitc = 0; if (ph == 4) ph = 2; else if (rd) ph = 3; end
    end
    always @(negedge i_scl) if (ph != 3)
    begin
        if (rd && ph == 2) o_sda_oe = (bitc < 8) ? !mem[ptr][7-bitc] : 1'b0;
        else if (bitc == 8)
        begin
            o_sda_oe = !i_nack && (ph != 0 || sh[7:1] == ADDR);
            if (ph == 0) rd = sh[0];
            else if (ph == 1 && !i_short) ptr = sh;
            else mem[ptr] = sh;
            // Phase 4 marks the acknowledge of a read address, data follows it
            ph = (ph != 0) ? 2 : (sh[0] ? 4 : 1);
        end
        else o_sda_oe = 1'b0;
    end
endmodule : tbam_target_model

// ==== tb_top.sv ====
// Purpose : Self-checking bench for the two-wire byte access master
// Assumes : Shortened quarter counts give a 160 ns bus bit at the normal rate
// Notes   : Reference memory tracks what the target should hold
`timescale 1ns/1ps
`include "tbam_consts.svh"
module tb_top;
    import tbam_pkg::*;
    localparam logic [6:0] TADDR = 7'h50;
    logic clk, rst_n, wr, rd, al_act, al_flt, scl, sda, short_mode, nack;
    logic scl_o, scl_oe, sda_o, sda_oe, tgt_oe, busy, link;
    logic       [7:0] addr, d, p;
    tbam_byte_t       wdata, rdata;
    int bad_count, checks, seed, ptr, j, n;
    int dur [8];
    int ref_mem [int];
    assign scl = !scl_oe;
    assign sda = !(sda_oe || tgt_oe);
    tbam_top #(.NORM_Q(16'h0004), .TEST_Q(16'h0002)) dut (.i_mclk(clk), .i_arst_n(rst_n), .i_cfg_addr(addr),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_autoload_active(al_act),
        .i_autoload_fault(al_flt), .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .o_request_in_flight(busy), .o_link_present(link));
    tbam_target_model #(.ADDR(TADDR)) tgt (.i_scl(scl), .i_sda(sda), .i_short(short_mode), .i_nack(nack),
        .o_sda_oe(tgt_oe));
    initial begin clk = 0; forever #5 clk = !clk; end
    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        checks++;
        if (seen !== exp) begin bad_count++; $display("BAD %s exp %h seen %h", nm, exp, seen); end
    endtask : chk
    task automatic cfg(input logic [7:0] a, input logic [7:0] v, input logic w);
        @(negedge clk); addr = a; wdata = v; wr = w; rd = !w;
        @(negedge clk); wr = 0; rd = 0;
    endtask : cfg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        cfg(a, 8'h00, 1'b0);
        @(negedge clk);
        chk(rdata, exp, nm);
    endtask : rd_chk
    task automatic wait_idle(output int cyc);
        cyc = 0;
        while (busy === 1'b1 && cyc < 5000) begin @(negedge clk); cyc++; end
        if (cyc >= 5000) begin bad_count++; results(); end
    endtask : wait_idle
    initial
    begin
        seed = 87;
        {wr, rd, al_act, al_flt, short_mode, nack} = '0;
        addr = 8'h00; wdata = 8'h00; rst_n = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
        repeat (6) @(negedge clk);
        rd_chk(`TBAM_OFF_TARGET, 8'h00, "target");
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h08, "status");
        chk(8'(link), 8'h01, "link_pin");
        chk(8'({scl_o, sda_o}), 8'h00, "open_drain");
        rd_chk(8'hb4, 8'h00, "unmapped");
        cfg(`TBAM_OFF_CTRL_STAT, 8'hff, 1'b1);
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h8c, "status");
        for (j = 0; j < 8; j++)
        begin
            d = 8'($random(seed));
            p = 8'($random(seed));
            short_mode = j[0];
            if (j[1]) p = ptr[7:0];
            if (!short_mode) ptr = p;
            cfg(`TBAM_OFF_XFER_BYTE, d, 1'b1);
            cfg(`TBAM_OFF_BYTE_PTR, p, 1'b1);
            cfg(`TBAM_OFF_CTRL_STAT, {short_mode, 4'h0, j[2], 2'b00}, 1'b1);
            cfg(`TBAM_OFF_TARGET, {TADDR, j[1]}, 1'b1);
            chk(busy, 1'b1, "in_flight");
            wait_idle(dur[j]);
            if (!j[1]) ref_mem[ptr] = d;
            rd_chk(`TBAM_OFF_XFER_BYTE, 8'(ref_mem[ptr]), "xfer");
            rd_chk(`TBAM_OFF_TARGET, {TADDR, j[1]}, "target");
            rd_chk(`TBAM_OFF_CTRL_STAT, {short_mode, 3'b000, 1'b1, j[2], 2'b00}, "status");
        end
        chk(8'(dur[4] < dur[0]), 8'h01, "rate");
        short_mode = 0;
        cfg(`TBAM_OFF_CTRL_STAT, 8'h00, 1'b1);
        cfg(`TBAM_OFF_TARGET, {TADDR, 1'b0}, 1'b1);
        cfg(`TBAM_OFF_TARGET, 8'h22, 1'b1);
        wait_idle(n);
        rd_chk(`TBAM_OFF_TARGET, {TADDR, 1'b0}, "target");
        nack = 1;
        cfg(`TBAM_OFF_TARGET, {TADDR, 1'b0}, 1'b1);
        wait_idle(n);
        nack = 0;
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h0a, "status");
        cfg(`TBAM_OFF_CTRL_STAT, 8'h02, 1'b1);
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h08, "status");
        al_act = 1;
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h18, "status");
        al_act = 0;
        al_flt = 1;
        @(negedge clk);
        al_flt = 0;
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h09, "status");
        cfg(`TBAM_OFF_CTRL_STAT, 8'h01, 1'b1);
        rd_chk(`TBAM_OFF_CTRL_STAT, 8'h08, "status");
        results();
    end
endmodule : tb_top
